// >>> rtl/line_monitor_pkg.sv
package line_monitor_pkg;

    // =========================================================
    // widths
    // =========================================================
    localparam int DATA_W          = 8;
    localparam int ADDR_W          = 8;
    localparam int SEL_W           = 3;
    localparam int NUM_TRANSISTORS = 6;
    localparam int MAG_W           = 6;
    localparam int SIGN_BIT        = 6;
    localparam int RESERVED_BIT    = 7;
    localparam int SYNC_DEPTH      = 2;

    // =========================================================
    // register offsets, all read-only
    // =========================================================
    localparam logic [ADDR_W-1:0] LINE_POWER_READOUT_OFS        = 8'h4D;
    localparam logic [ADDR_W-1:0] LOOP_VOLTAGE_READOUT_OFS      = 8'h4E;
    localparam logic [ADDR_W-1:0] LOOP_CURRENT_READOUT_OFS      = 8'h4F;
    localparam logic [ADDR_W-1:0] TIP_VOLTAGE_READOUT_OFS       = 8'h50;
    localparam logic [ADDR_W-1:0] RING_VOLTAGE_READOUT_OFS      = 8'h51;
    localparam logic [ADDR_W-1:0] BATTERY_VOLTAGE_READOUT_A_OFS = 8'h52;
    localparam logic [ADDR_W-1:0] BATTERY_VOLTAGE_READOUT_B_OFS = 8'h53;
    localparam logic [ADDR_W-1:0] DRIVE_CURRENT_READOUT_A_OFS   = 8'h54;

    // =========================================================
    // reset and fixed values
    // =========================================================
    localparam logic [DATA_W-1:0] READOUT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [MAG_W-1:0]  MAG_MAX       = 6'h3F;

    // =========================================================
    // power monitor select codes
    // =========================================================
    localparam logic [SEL_W-1:0] SEL_Q1 = 3'h0;
    localparam logic [SEL_W-1:0] SEL_Q2 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_Q3 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_Q4 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_Q5 = 3'h4;
    localparam logic [SEL_W-1:0] SEL_Q6 = 3'h5;

    // =========================================================
    // code scales, applied by the analog path
    // =========================================================
    localparam real POWER_STEP_MW_WIDE   = 30.4;
    localparam real POWER_STEP_MW_NARROW = 3.62;
    localparam real LOOP_V_STEP_V        = 1.5;
    localparam real LOOP_V_MAX_V         = 94.5;
    localparam real LOOP_I_STEP_MA       = 1.25;
    localparam real LOOP_I_MAX_MA        = 78.75;
    localparam real LINE_V_STEP_V        = 0.376;
    localparam real DRIVE_I_STEP_MA      = 0.319;

    // =========================================================
    // carriers
    // =========================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // loop voltage and current arrive signed, in magnitude steps
    typedef struct packed {
        logic [NUM_TRANSISTORS-1:0][DATA_W-1:0] power;
        logic [DATA_W-1:0]                      loop_voltage;
        logic [DATA_W-1:0]                      loop_current;
        logic [DATA_W-1:0]                      tip_voltage;
        logic [DATA_W-1:0]                      ring_voltage;
        logic [DATA_W-1:0]                      battery_voltage;
        logic [DATA_W-1:0]                      drive_current_a;
        logic [DATA_W-1:0]                      extended_bias_current;
    } meas_t;

endpackage

// >>> rtl/meas_sync.sv
`timescale 1ns/10ps
module meas_sync
    import line_monitor_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = SYNC_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // =========================================================
    // elaboration checks
    // =========================================================
    if (DEPTH < 2) begin : g_bad_depth
        $error("meas_sync needs at least two stages");
    end

    // =========================================================
    // synchroniser chain
    // =========================================================
    // the analog path samples asynchronously; values are settled codes,
    // so a bus of flops is enough and a torn code lasts one cycle only
    logic [DEPTH-1:0][WIDTH-1:0] stage;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= '0;
        end else begin
            stage[0] <= d;
            for (int i = 1; i < DEPTH; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q = stage[DEPTH-1];

endmodule

// >>> rtl/line_monitor_readback.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// RULE_01: line power readout follows the transistor picked by the select field.
// RULE_02: q1, q2, q5, q6 power codes run 0x00 to 0xFF at 30.4 mW per step.
// RULE_03: q3 and q4 power codes run from 0x00 at 3.62 mW per step.
// RULE_04: loop voltage bit 6 is 0 for tip above ring, 1 for below.
// RULE_05: loop voltage bits 5:0 give magnitude, 1.5 V steps, up to 94.5 V.
// RULE_06: loop current bit 6 is 0 forward, 1 reverse.
// RULE_07: loop current bits 5:0 give magnitude, 1.25 mA steps, to 78.75 mA.
// RULE_08: tip readout gives live tip voltage, 0x00 at zero, .376 V per step.
// RULE_09: ring readout gives live ring voltage, 0x00 at zero, .376 V per step.
// RULE_10: two battery readouts each give live battery voltage at .376 V per step.
// RULE_11: drive current readout gives live q1 current at .319 mA per step.
// RULE_12: with extended bias enabled, the added bias current is left out.
// RULE_13: select codes 000 to 101 pick q1 to q6; 110 and 111 undefined.
// RULE_14: reserved bit 7 of loop readouts reads zero; writes change nothing.
module line_monitor_readback
    import line_monitor_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire reg_req_t          req,
    output logic      [DATA_W-1:0] rdata,
    input  wire meas_t             meas,
    input  wire logic [SEL_W-1:0]  power_monitor_select,
    input  wire logic              extended_bias_enable
);

    // =========================================================
    // measurement crossing
    // =========================================================
    // every analog sample passes two flops before any logic reads it
    meas_t meas_s;
    meas_t meas_in;

    assign meas_in = meas;

    meas_sync #(
        .WIDTH ($bits(meas_t)),
        .DEPTH (SYNC_DEPTH)
    ) u_meas_sync (
        .clk (clk),
        .rst (rst),
        .d   (meas_in),
        .q   (meas_s)
    );

    // =========================================================
    // readout registers
    // =========================================================
    logic [DATA_W-1:0] line_power_readout;
    logic [DATA_W-1:0] loop_voltage_readout;
    logic [DATA_W-1:0] loop_current_readout;
    logic [DATA_W-1:0] tip_voltage_readout;
    logic [DATA_W-1:0] ring_voltage_readout;
    logic [DATA_W-1:0] battery_voltage_readout_a;
    logic [DATA_W-1:0] battery_voltage_readout_b;
    logic [DATA_W-1:0] drive_current_readout_a;

    logic [DATA_W-1:0] next_line_power;
    logic [DATA_W-1:0] next_drive_current;
    logic [DATA_W-1:0] next_rdata;

    // =========================================================
    // power monitor selection
    // =========================================================
    // the select value comes from the neighbouring config register on
    // this clock, so it is used directly; undefined codes report zero
    logic                     sel_valid;
    logic [DATA_W-1:0]        selected_power;
    logic                     sel_narrow_range;

    assign sel_valid = (power_monitor_select <= SEL_Q6);                  // [RULE_13]
    // the analog path scales each channel; q3/q4 run on the fine step
    assign sel_narrow_range = (power_monitor_select == SEL_Q3) ||
                              (power_monitor_select == SEL_Q4);          // [RULE_03]
    assign selected_power = sel_valid ?
                            meas_s.power[power_monitor_select] : READOUT_RESET; // [RULE_01]
    // code passes through unchanged, full 0x00..0xFF span for either range
    assign next_line_power = selected_power;                              // [RULE_02]

    // =========================================================
    // loop sign and magnitude
    // =========================================================
    // both loop channels share one conversion: sign from the signed
    // sample, magnitude saturated at the six-bit ceiling
    logic [1:0][DATA_W-1:0] loop_raw;
    logic [1:0][DATA_W-1:0] loop_code;

    assign loop_raw[0] = meas_s.loop_voltage;
    assign loop_raw[1] = meas_s.loop_current;

    for (genvar g = 0; g < 2; g++) begin : g_loop
        logic              neg;
        logic [DATA_W-1:0] abs_val;
        logic [MAG_W-1:0]  mag;

        assign neg     = loop_raw[g][DATA_W-1];                           // [RULE_04] [RULE_06]
        assign abs_val = neg ? DATA_W'(~loop_raw[g] + 8'h01) : loop_raw[g];
        // saturate rather than wrap so an overload never reads small
        assign mag     = (abs_val > DATA_W'(MAG_MAX)) ?
                         MAG_MAX : abs_val[MAG_W-1:0];                    // [RULE_05] [RULE_07]
        assign loop_code[g] = {1'b0, neg, mag};                           // [RULE_14]
    end

    // =========================================================
    // drive current with bias excluded
    // =========================================================
    // subtraction floors at zero; a bias estimate above the sensed
    // current would otherwise wrap to a huge reading
    logic bias_exceeds;

    assign bias_exceeds       = meas_s.extended_bias_current > meas_s.drive_current_a;
    assign next_drive_current = !extended_bias_enable ? meas_s.drive_current_a :
                                bias_exceeds ? READOUT_RESET :
                                DATA_W'(meas_s.drive_current_a -
                                        meas_s.extended_bias_current);    // [RULE_12]

    // =========================================================
    // live update
    // =========================================================
    // readouts refresh every cycle; bus writes never reach them
    always_ff @(posedge clk) begin
        if (rst) begin
            line_power_readout        <= READOUT_RESET;
            loop_voltage_readout      <= READOUT_RESET;
            loop_current_readout      <= READOUT_RESET;
            tip_voltage_readout       <= READOUT_RESET;
            ring_voltage_readout      <= READOUT_RESET;
            battery_voltage_readout_a <= READOUT_RESET;
            battery_voltage_readout_b <= READOUT_RESET;
            drive_current_readout_a   <= READOUT_RESET;
        end else begin
            line_power_readout        <= next_line_power;                 // [RULE_01]
            loop_voltage_readout      <= loop_code[0];                    // [RULE_05]
            loop_current_readout      <= loop_code[1];                    // [RULE_07]
            tip_voltage_readout       <= meas_s.tip_voltage;              // [RULE_08]
            ring_voltage_readout      <= meas_s.ring_voltage;             // [RULE_09]
            battery_voltage_readout_a <= meas_s.battery_voltage;          // [RULE_10]
            battery_voltage_readout_b <= meas_s.battery_voltage;          // [RULE_10]
            drive_current_readout_a   <= next_drive_current;              // [RULE_11]
        end
    end

    // =========================================================
    // register read port
    // =========================================================
    // write strobes are decoded nowhere: every register here is read-only
    logic hit_power;
    logic hit_lv;
    logic hit_lc;
    logic hit_tip;
    logic hit_ring;
    logic hit_bat_a;
    logic hit_bat_b;
    logic hit_drive;

    assign hit_power = (req.addr == LINE_POWER_READOUT_OFS);
    assign hit_lv    = (req.addr == LOOP_VOLTAGE_READOUT_OFS);
    assign hit_lc    = (req.addr == LOOP_CURRENT_READOUT_OFS);
    assign hit_tip   = (req.addr == TIP_VOLTAGE_READOUT_OFS);
    assign hit_ring  = (req.addr == RING_VOLTAGE_READOUT_OFS);
    assign hit_bat_a = (req.addr == BATTERY_VOLTAGE_READOUT_A_OFS);
    assign hit_bat_b = (req.addr == BATTERY_VOLTAGE_READOUT_B_OFS);
    assign hit_drive = (req.addr == DRIVE_CURRENT_READOUT_A_OFS);

    // read data stand only in the cycle after the strobe, zero otherwise
    assign next_rdata = !req.rd  ? UNMAPPED_READ :
                        hit_power ? line_power_readout :
                        hit_lv    ? loop_voltage_readout :
                        hit_lc    ? loop_current_readout :
                        hit_tip   ? tip_voltage_readout :
                        hit_ring  ? ring_voltage_readout :
                        hit_bat_a ? battery_voltage_readout_a :
                        hit_bat_b ? battery_voltage_readout_b :
                        hit_drive ? drive_current_readout_a :
                        UNMAPPED_READ;                                    // [RULE_14]

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= UNMAPPED_READ;
        end else begin
            rdata <= next_rdata;
        end
    end

    // =========================================================
    // assertions
    // =========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic past_valid;

    always_ff @(posedge clk) begin
        if (rst) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    sequence s_read_tip;
        req.rd && hit_tip;
    endsequence

    sequence s_tip_answer;
        ##1 (rdata == $past(tip_voltage_readout));
    endsequence

    property p_power_follows_select;
        past_valid && sel_valid |=>
            line_power_readout == $past(meas_s.power[power_monitor_select]);
    endproperty
    a_power_follows_select: assert property (p_power_follows_select) // [RULE_01]
        else $error("line power does not follow selected transistor");

    property p_power_narrow_passthrough;
        past_valid && sel_narrow_range |=>
            line_power_readout == $past(meas_s.power[power_monitor_select]);
    endproperty
    a_power_narrow_passthrough: assert property (p_power_narrow_passthrough) // [RULE_03]
        else $error("narrow range power code altered");

    property p_power_undefined_zero;
        !sel_valid |=> line_power_readout == READOUT_RESET;
    endproperty
    a_power_undefined_zero: assert property (p_power_undefined_zero) // [RULE_13]
        else $error("undefined select did not read zero");

    property p_lv_sign;
        past_valid |-> loop_voltage_readout[SIGN_BIT] == $past(meas_s.loop_voltage[DATA_W-1]);
    endproperty
    a_lv_sign: assert property (p_lv_sign) // [RULE_04]
        else $error("loop voltage sign wrong");

    property p_lv_mag_small;
        !meas_s.loop_voltage[DATA_W-1] && meas_s.loop_voltage <= DATA_W'(MAG_MAX) |=>
            loop_voltage_readout[MAG_W-1:0] == $past(meas_s.loop_voltage[MAG_W-1:0]);
    endproperty
    a_lv_mag_small: assert property (p_lv_mag_small) // [RULE_05]
        else $error("loop voltage magnitude wrong");

    property p_lc_saturate;
        !meas_s.loop_current[DATA_W-1] && meas_s.loop_current > DATA_W'(MAG_MAX) |=>
            loop_current_readout[MAG_W-1:0] == MAG_MAX;
    endproperty
    a_lc_saturate: assert property (p_lc_saturate) // [RULE_07]
        else $error("loop current magnitude did not saturate");

    property p_lc_sign;
        meas_s.loop_current[DATA_W-1] |=> loop_current_readout[SIGN_BIT];
    endproperty
    a_lc_sign: assert property (p_lc_sign) // [RULE_06]
        else $error("reverse loop current not flagged");

    property p_reserved_zero;
        !loop_voltage_readout[RESERVED_BIT] && !loop_current_readout[RESERVED_BIT];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE_14]
        else $error("reserved loop bit set");

    property p_tip_latency;
        past_valid |=> tip_voltage_readout == $past(meas_s.tip_voltage);
    endproperty
    a_tip_latency: assert property (p_tip_latency) // [RULE_08]
        else $error("tip readout not live");

    property p_battery_copies;
        past_valid |-> battery_voltage_readout_a == battery_voltage_readout_b &&
            battery_voltage_readout_a == $past(meas_s.battery_voltage);
    endproperty
    a_battery_copies: assert property (p_battery_copies) // [RULE_10]
        else $error("battery copies differ");

    property p_bias_excluded;
        extended_bias_enable && !bias_exceeds |=>
            drive_current_readout_a ==
            $past(DATA_W'(meas_s.drive_current_a - meas_s.extended_bias_current));
    endproperty
    a_bias_excluded: assert property (p_bias_excluded) // [RULE_12]
        else $error("bias current not excluded");

    property p_drive_plain;
        !extended_bias_enable |=> drive_current_readout_a == $past(meas_s.drive_current_a);
    endproperty
    a_drive_plain: assert property (p_drive_plain) // [RULE_11]
        else $error("drive current readout wrong");

    property p_read_tip;
        s_read_tip |-> s_tip_answer;
    endproperty
    a_read_tip: assert property (p_read_tip) // [RULE_08]
        else $error("read data wrong or late");

    property p_idle_rdata_zero;
        !req.rd |=> rdata == UNMAPPED_READ;
    endproperty
    a_idle_rdata_zero: assert property (p_idle_rdata_zero) // [RULE_14]
        else $error("read data outside answer cycle");

    property p_write_ignored;
        req.wr && !req.rd |=> rdata == UNMAPPED_READ;
    endproperty
    a_write_ignored: assert property (p_write_ignored) // [RULE_14]
        else $error("write produced read data");

    property p_ring_latency;
        past_valid |=> ring_voltage_readout == $past(meas_s.ring_voltage);
    endproperty
    a_ring_latency: assert property (p_ring_latency) // [RULE_09]
        else $error("ring readout not live");

    property p_lv_saturate;
        !meas_s.loop_voltage[DATA_W-1] && meas_s.loop_voltage > DATA_W'(MAG_MAX) |=>
            loop_voltage_readout[MAG_W-1:0] == MAG_MAX;
    endproperty
    a_lv_saturate: assert property (p_lv_saturate) // [RULE_05]
        else $error("loop voltage magnitude did not saturate");

    // negative samples must read as their magnitude, never as the raw code
    property p_lv_negative;
        meas_s.loop_voltage[DATA_W-1] && DATA_W'(-meas_s.loop_voltage) <= DATA_W'(MAG_MAX) |=>
            loop_voltage_readout[MAG_W-1:0] == MAG_W'($past(DATA_W'(-meas_s.loop_voltage)));
    endproperty
    a_lv_negative: assert property (p_lv_negative) // [RULE_05]
        else $error("negative loop voltage magnitude wrong");

    property p_lc_mag_small;
        !meas_s.loop_current[DATA_W-1] && meas_s.loop_current <= DATA_W'(MAG_MAX) |=>
            loop_current_readout[MAG_W-1:0] == $past(meas_s.loop_current[MAG_W-1:0]);
    endproperty
    a_lc_mag_small: assert property (p_lc_mag_small) // [RULE_07]
        else $error("loop current magnitude wrong");

    property p_bias_floor;
        extended_bias_enable &&
            meas_s.extended_bias_current > meas_s.drive_current_a |=>
            drive_current_readout_a == READOUT_RESET;
    endproperty
    a_bias_floor: assert property (p_bias_floor) // [RULE_12]
        else $error("drive current did not floor at zero");

    property p_read_power;
        req.rd && hit_power |=> rdata == $past(line_power_readout);
    endproperty
    a_read_power: assert property (p_read_power) // [RULE_01]
        else $error("line power read data wrong");

    property p_read_drive;
        req.rd && hit_drive |=> rdata == $past(drive_current_readout_a);
    endproperty
    a_read_drive: assert property (p_read_drive) // [RULE_11]
        else $error("drive current read data wrong");

endmodule

// >>> sim/testbench.sv
`timescale 1ns/10ps
module testbench
    import line_monitor_pkg::*;
;

    // =========================================================
    // signals and counters
    // =========================================================
    logic              clk;
    logic              rst;
    reg_req_t          req;
    logic [DATA_W-1:0] rdata;
    meas_t             meas;
    logic [SEL_W-1:0]  power_monitor_select;
    logic              extended_bias_enable;
    int                err_count;
    int                check_count;
    int                cycles;
    logic [7:0]        last_addr;
    logic [7:0]        corner [8];

    line_monitor_readback dut (
        .clk                  (clk),
        .rst                  (rst),
        .req                  (req),
        .rdata                (rdata),
        .meas                 (meas),
        .power_monitor_select (power_monitor_select),
        .extended_bias_enable (extended_bias_enable)
    );

    // =========================================================
    // clock and hang guard
    // =========================================================
    always #12.5 clk = ~clk;

    // a full run needs under 2400 cycles, so this only trips on a stall
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("ERROR %0t: run did not finish in time", $time);
            finish_test();
        end
    end

    // =========================================================
    // shared tasks
    // =========================================================
    task automatic finish_test();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: addr 0x%02h read 0x%02h expected 0x%02h",
                     $time, last_addr, seen, exp);
        end
    endtask

    // write left standing one cycle; the following read replaces it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    // rdata must be idle in the strobe cycle and carry data one cycle later
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        last_addr = a;
        #1 check(rdata, 8'h00);
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // =========================================================
    // expected readouts
    // =========================================================
    // sign from the sample msb, magnitude saturated at the field top
    function automatic logic [7:0] loop_code(input logic [7:0] s);
        logic [7:0] a;
        a = s[7] ? (~s + 8'h01) : s;
        if (a > 8'h3F) begin
            a = 8'h3F;
        end
        return {1'b0, s[7], a[5:0]};
    endfunction

    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        logic [7:0] d;
        logic [7:0] b;
        d = meas.drive_current_a;
        b = meas.extended_bias_current;
        case (a)
            LINE_POWER_READOUT_OFS: begin
                return (power_monitor_select < 3'h6) ? meas.power[power_monitor_select] : 8'h00;
            end
            LOOP_VOLTAGE_READOUT_OFS:      return loop_code(meas.loop_voltage);
            LOOP_CURRENT_READOUT_OFS:      return loop_code(meas.loop_current);
            TIP_VOLTAGE_READOUT_OFS:       return meas.tip_voltage;
            RING_VOLTAGE_READOUT_OFS:      return meas.ring_voltage;
            BATTERY_VOLTAGE_READOUT_A_OFS: return meas.battery_voltage;
            BATTERY_VOLTAGE_READOUT_B_OFS: return meas.battery_voltage;
            DRIVE_CURRENT_READOUT_A_OFS: begin
                return !extended_bias_enable ? d : ((d > b) ? d - b : 8'h00);
            end
            default:                       return UNMAPPED_READ;
        endcase
    endfunction

    // =========================================================
    // main sequence
    // =========================================================
    initial begin
        logic [127:0] r;
        meas_t        m;
        logic [7:0]   v;
        logic [7:0]   a;
        corner = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'h81, 8'hC1, 8'hFF};
        void'($urandom(32'h4A8D));
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        cycles = 0;
        err_count = 0;
        check_count = 0;
        last_addr = 8'h00;
        r = {$urandom, $urandom, $urandom, $urandom};
        meas = r[103:0];
        power_monitor_select = 3'h0;
        extended_bias_enable = 1'b0;
        // live inputs must not leak through while reset is held
        repeat (8) begin
            @(posedge clk);
            #1 check(rdata, READOUT_RESET);
        end
        rst <= 1'b0;
        rd_reg(TIP_VOLTAGE_READOUT_OFS, v);
        check(v, READOUT_RESET);
        for (int i = 0; i < 40; i++) begin
            r = {$urandom, $urandom, $urandom, $urandom};
            m = r[103:0];
            if (i < 8) begin
                m.loop_voltage = corner[i];
                m.loop_current = corner[7-i];
            end
            if (i % 4 == 1) begin
                m.extended_bias_current = m.drive_current_a + 8'h01;
            end
            @(posedge clk);
            meas <= m;
            power_monitor_select <= 3'($urandom_range(0, 7));
            extended_bias_enable <= 1'($urandom_range(0, 1));
            repeat (3) @(posedge clk);
            // write straight before reading the same place back
            a = 8'($urandom_range(8'h4D, 8'h54));
            wr_reg(a, 8'($urandom));
            rd_reg(a, v);
            check(v, exp_reg(a));
            for (int k = 8'h4C; k <= 8'h55; k++) begin
                rd_reg(8'(k), v);
                check(v, exp_reg(8'(k)));
            end
            a = 8'($urandom_range(8'h55, 8'hFF));
            rd_reg(a, v);
            check(v, exp_reg(a));
            // every select code with the measurements held still
            for (int s = 0; s < 8; s++) begin
                @(posedge clk);
                power_monitor_select <= 3'(s);
                rd_reg(LINE_POWER_READOUT_OFS, v);
                check(v, exp_reg(LINE_POWER_READOUT_OFS));
            end
            // bias exclusion toggled under an unchanged current sample
            for (int t = 0; t < 2; t++) begin
                @(posedge clk);
                extended_bias_enable <= ~extended_bias_enable;
                rd_reg(DRIVE_CURRENT_READOUT_A_OFS, v);
                check(v, exp_reg(DRIVE_CURRENT_READOUT_A_OFS));
            end
        end
        finish_test();
    end

endmodule
